//--- include/handoff_pkg.sv
package handoff_pkg;

    // ************************************************
    // synchroniser and strap timing
    // ************************************************
    localparam int SYNC_STAGES          = 3;
    // cycles after reset release before a synced level is trusted
    localparam logic [1:0] STRAP_WAIT   = 2'h3;

    // ************************************************
    // initialisation sequence
    // ************************************************
    localparam logic [5:0] INIT_REFRESH_COUNT = 6'h20;
    localparam logic [31:0] FIRST_FILL_ADDR   = 32'hFFFFFFC0;

    // ************************************************
    // refresh backlog
    // ************************************************
    localparam int BACKLOG_WIDTH           = 8;
    localparam logic [7:0] URGENT_BACKLOG  = 8'h10;

    // ************************************************
    // reset values
    // ************************************************
    localparam logic GRANT_N_RESET   = 1'b1;
    localparam logic FLOAT_RESET     = 1'b1;
    localparam logic REQ_LVL_RESET   = 1'b1;
    localparam logic PRIORITY_RESET  = 1'b0;

    typedef enum {
        BUS_OWN,
        BUS_DRAIN,
        BUS_GRANT
    } bus_state_t;

    typedef enum {
        SEQ_STRAP,
        SEQ_REFRESH,
        SEQ_DEACTIVATE_ALL_BANKS,
        SEQ_FILL,
        SEQ_RUN
    } seq_state_t;

endpackage

//--- sim/host_bus_handoff_and_reset_monitor.sv
module handoff_monitor
    import handoff_pkg::*;
#(
    parameter int BACKLOG_W = 8
) (
    input wire logic                 ref_clk,
    input wire logic                 resetn,
    input wire logic                 host_bus_request_n,
    input wire logic                 pipe_busy,
    input wire logic [BACKLOG_W-1:0] refresh_backlog,
    input wire logic                 external_packet_transfer_pend,
    input wire logic                 host_bus_grant_n,
    input wire logic                 bus_float,
    input wire logic                 launch_enable,
    input wire logic                 priority_req,
    input wire logic                 first_fill_req,
    input wire logic [31:0]          first_fill_addr,
    input wire logic                 cfg_present_clear,
    input wire logic                 refresh_ctrl_reset,
    input wire logic                 requests_abort,
    input wire logic                 ctrl_state_reset,
    input wire logic                 processor_reset,
    input wire logic                 big_endian
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************
    // handoff and reset properties
    // ************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    property p_grant_float;
        !host_bus_grant_n |-> bus_float;
    endproperty
    a_grant_float: assert property (p_grant_float) else $error("grant while bus driven");
    property p_priority;
        $past(resetn) |-> priority_req ==
            $past(refresh_backlog >= URGENT_BACKLOG || external_packet_transfer_pend);
    endproperty
    a_priority: assert property (p_priority) else $error("priority output wrong");
    property p_no_withdraw;
        $rose(host_bus_grant_n) |-> $past(host_bus_request_n, 2);
    endproperty
    a_no_withdraw: assert property (p_no_withdraw) else $error("grant withdrawn");
    property p_stop_launch;
        $fell(host_bus_request_n) ##1 !host_bus_request_n [*6] |-> !launch_enable;
    endproperty
    a_stop_launch: assert property (p_stop_launch) else $error("launch not stopped");
    property p_drain;
        $fell(host_bus_grant_n) |-> !$past(pipe_busy);
    endproperty
    a_drain: assert property (p_drain) else $error("grant before drain");
    property p_grant;
        $fell(host_bus_request_n) ##1 (!host_bus_request_n && !pipe_busy) [*7] |-> !host_bus_grant_n;
    endproperty
    a_grant: assert property (p_grant) else $error("grant missing");
    property p_release;
        $rose(host_bus_request_n) ##1 host_bus_request_n [*6] |-> host_bus_grant_n && !bus_float;
    endproperty
    a_release: assert property (p_release) else $error("bus not returned");
    property p_endian;
        $changed(big_endian) |-> !$past(resetn, 4) || !$past(resetn, 5) || !$past(resetn, 6);
    endproperty
    a_endian: assert property (p_endian) else $error("endian changed in run");
    property p_hw_clear;
        $past(resetn) |-> !cfg_present_clear && !refresh_ctrl_reset;
    endproperty
    a_hw_clear: assert property (p_hw_clear) else $error("cache cleared outside reset");
    property p_soft_pulse;
        $rose(processor_reset) |-> requests_abort && ctrl_state_reset ##1 !processor_reset;
    endproperty
    a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset pulse wrong");
    property p_fill_addr;
        first_fill_req |-> first_fill_addr == FIRST_FILL_ADDR && host_bus_grant_n && !bus_float;
    endproperty
    a_fill_addr: assert property (p_fill_addr) else $error("fill address wrong");
endmodule // handoff_monitor

bind host_bus_handoff_and_reset handoff_monitor #(.BACKLOG_W(BACKLOG_W)) u_handoff_monitor (
    .ref_clk, .resetn, .host_bus_request_n, .pipe_busy, .refresh_backlog,
    .external_packet_transfer_pend, .host_bus_grant_n, .bus_float, .launch_enable,
    .priority_req, .first_fill_req, .first_fill_addr, .cfg_present_clear,
    .refresh_ctrl_reset, .requests_abort, .ctrl_state_reset, .processor_reset, .big_endian
);

//--- sim/host_bus_handoff_and_reset_test.sv
module host_bus_handoff_and_reset_test
    import handoff_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        resetn, ready_pin, external_interrupt_three, pipe_busy, want;
    logic        external_packet_transfer_pend, refresh_done, sdram_present;
    logic        deactivate_all_banks_done, fill_done, sw_reset_cmd, host_bus_request_n;
    logic [7:0]  refresh_backlog;
    logic        host_bus_grant_n, bus_float, launch_enable, priority_req;
    logic        init_refresh_req, deactivate_all_banks_req, first_fill_req, cfg_present_clear;
    logic        refresh_ctrl_reset, requests_abort, ctrl_state_reset;
    logic        processor_reset, master_processor_halted, big_endian;
    logic [31:0] first_fill_addr;
    int          num_errors = 0;
    int          checked = 0;
    typedef struct {logic [7:0] backlog; logic external_packet_transfer; logic prio;} row_t;
    row_t        rows [5] = '{'{8'h0F, 1'b0, 1'b0}, '{8'h10, 1'b0, 1'b1},
                              '{8'hFF, 1'b0, 1'b1}, '{8'h00, 1'b1, 1'b1},
                              '{8'h00, 1'b0, 1'b0}};

    always #2 ref_clk = ~ref_clk;

    host_bus_handoff_and_reset u_host_bus_handoff_and_reset (
        .ref_clk, .resetn, .host_bus_request_n, .ready_pin, .external_interrupt_three,
        .pipe_busy, .refresh_backlog, .external_packet_transfer_pend, .refresh_done,
        .sdram_present, .deactivate_all_banks_done, .fill_done, .sw_reset_cmd, .host_bus_grant_n,
        .bus_float, .launch_enable, .priority_req, .init_refresh_req, .deactivate_all_banks_req,
        .first_fill_req, .first_fill_addr, .cfg_present_clear, .refresh_ctrl_reset,
        .requests_abort, .ctrl_state_reset, .processor_reset, .master_processor_halted,
        .big_endian
    );
    host_device_model u_host_device_model (.ref_clk, .want, .priority_req, .host_bus_request_n);

    // ************************************************
    // shared tasks
    // ************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // outputs read at an edge are the values that stood through the previous cycle
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wait_grant(input logic v);
        for (int i = 0; i < 40 && host_bus_grant_n !== v; i++) cyc(1);
        chk(host_bus_grant_n, v);
    endtask
    task automatic refreshes(input int n);
        repeat (n) begin
            refresh_done <= 1'b1;
            cyc(1);
            refresh_done <= 1'b0;
            cyc(1);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        cyc(20000);
        num_errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        {resetn, external_interrupt_three, pipe_busy, want, refresh_done} = '0;
        {external_packet_transfer_pend, deactivate_all_banks_done, fill_done, sw_reset_cmd} = '0;
        {ready_pin, sdram_present} = 2'h3;
        refresh_backlog = 8'h00;
        cyc(5);
        chk(bus_float, 1'b1);
        chk(host_bus_grant_n, 1'b1);
        chk(requests_abort, 1'b1);
        chk(processor_reset, 1'b1);
        resetn <= 1'b1;
        cyc(10);
        chk(bus_float, 1'b0);
        chk(big_endian, 1'b0);
        chk(master_processor_halted, 1'b1);
        chk(init_refresh_req, 1'b1);
        refreshes(10);
        want <= 1'b1;
        wait_grant(1'b0);
        chk(init_refresh_req, 1'b0);
        want <= 1'b0;
        wait_grant(1'b1);
        cyc(3);
        chk(init_refresh_req, 1'b1);
        refreshes(21);
        cyc(2);
        chk(init_refresh_req, 1'b1);
        refreshes(1);
        cyc(3);
        chk(init_refresh_req, 1'b0);
        chk(deactivate_all_banks_req, 1'b1);
        deactivate_all_banks_done <= 1'b1;
        cyc(1);
        deactivate_all_banks_done <= 1'b0;
        cyc(4);
        chk(deactivate_all_banks_req, 1'b0);
        chk(first_fill_req, 1'b0);
        external_interrupt_three <= 1'b1;
        cyc(6);
        external_interrupt_three <= 1'b0;
        chk(master_processor_halted, 1'b0);
        cyc(2);
        chk(first_fill_req, 1'b1);
        chk(first_fill_addr, FIRST_FILL_ADDR);
        fill_done <= 1'b1;
        cyc(1);
        fill_done <= 1'b0;
        cyc(3);
        chk(first_fill_req, 1'b0);
        foreach (rows[i]) begin
            refresh_backlog <= rows[i].backlog;
            external_packet_transfer_pend <= rows[i].external_packet_transfer;
            cyc(3);
            chk(priority_req, rows[i].prio);
        end
        // ************************************************
        // awkward cases
        // ************************************************
        pipe_busy <= 1'b1;
        want <= 1'b1;
        cyc(10);
        chk(launch_enable, 1'b0);
        chk(host_bus_grant_n, 1'b1);
        pipe_busy <= 1'b0;
        wait_grant(1'b0);
        chk(bus_float, 1'b1);
        cyc(30);
        chk(host_bus_grant_n, 1'b0);
        refresh_backlog <= URGENT_BACKLOG;
        wait_grant(1'b1);
        chk(bus_float, 1'b0);
        chk(launch_enable, 1'b1);
        want <= 1'b0;
        refresh_backlog <= 8'h00;
        cyc(5);
        pipe_busy <= 1'b1;
        sw_reset_cmd <= 1'b1;
        ready_pin <= 1'b0;
        cyc(1);
        sw_reset_cmd <= 1'b0;
        cyc(4);
        chk(processor_reset, 1'b0);
        chk(launch_enable, 1'b0);
        pipe_busy <= 1'b0;
        for (int i = 0; i < 10 && processor_reset !== 1'b1; i++) cyc(1);
        chk(processor_reset, 1'b1);
        chk(requests_abort, 1'b1);
        chk(ctrl_state_reset, 1'b1);
        chk(cfg_present_clear, 1'b0);
        chk(refresh_ctrl_reset, 1'b0);
        cyc(1);
        chk(processor_reset, 1'b0);
        cyc(3);
        chk(launch_enable, 1'b1);
        chk(big_endian, 1'b0);
        resetn <= 1'b0;
        want <= 1'b1;
        #1;
        chk(bus_float, 1'b1);
        cyc(5);
        resetn <= 1'b1;
        cyc(12);
        chk(host_bus_grant_n, 1'b0);
        chk(bus_float, 1'b1);
        chk(init_refresh_req, 1'b0);
        chk(big_endian, 1'b1);
        chk(master_processor_halted, 1'b0);
        want <= 1'b0;
        wait_grant(1'b1);
        cyc(3);
        chk(init_refresh_req, 1'b1);
        stop_test();
    end
endmodule // host_bus_handoff_and_reset_test

//--- sim/host_device_model.sv
module host_device_model (
    input  wire logic ref_clk,
    input  wire logic want,
    input  wire logic priority_req,
    output logic      host_bus_request_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************
    // host request pin
    // ************************************************
    initial host_bus_request_n = 1'b1;
    // urgent work on the far side ends or holds off our ownership
    always @(posedge ref_clk) begin
        host_bus_request_n <= !(want && !priority_req);
    end
endmodule // host_device_model

//--- verilog/host_bus_handoff_and_reset.sv
module host_bus_handoff_and_reset
    import handoff_pkg::*;
#(
    parameter int BACKLOG_W = handoff_pkg::BACKLOG_WIDTH
) (
    input  wire logic                 ref_clk,
    input  wire logic                 resetn,
    input  wire logic                 host_bus_request_n,
    input  wire logic                 ready_pin,
    input  wire logic                 external_interrupt_three,
    input  wire logic                 pipe_busy,
    input  wire logic [BACKLOG_W-1:0] refresh_backlog,
    input  wire logic                 external_packet_transfer_pend,
    input  wire logic                 refresh_done,
    input  wire logic                 sdram_present,
    input  wire logic                 deactivate_all_banks_done,
    input  wire logic                 fill_done,
    input  wire logic                 sw_reset_cmd,
    output logic                      host_bus_grant_n,
    output logic                      bus_float,
    output logic                      launch_enable,
    output logic                      priority_req,
    output logic                      init_refresh_req,
    output logic                      deactivate_all_banks_req,
    output logic                      first_fill_req,
    output logic [31:0]               first_fill_addr,
    output logic                      cfg_present_clear,
    output logic                      refresh_ctrl_reset,
    output logic                      requests_abort,
    output logic                      ctrl_state_reset,
    output logic                      processor_reset,
    output logic                      master_processor_halted,
    output logic                      big_endian
);
    import handoff_pkg::*;

    // ************************************************
    // pin synchronisers
    // ************************************************
    logic [SYNC_STAGES-1:0] req_sync_reg;
    logic [SYNC_STAGES-1:0] rdy_sync_reg;
    logic [SYNC_STAGES-1:0] int3_sync_reg;
    logic                   req_lvl_reg;
    logic                   rdy_lvl_reg;
    logic                   int3_lvl_reg;
    logic                   int3_prev_reg;

    // a level changes only once stages two and three agree
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            req_sync_reg <= {SYNC_STAGES{REQ_LVL_RESET}};
            req_lvl_reg  <= REQ_LVL_RESET;
        end else begin
            req_sync_reg <= {req_sync_reg[SYNC_STAGES-2:0], host_bus_request_n};
            if (req_sync_reg[1] == req_sync_reg[2]) begin
                req_lvl_reg <= req_sync_reg[2];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdy_sync_reg <= '0;
            rdy_lvl_reg  <= 1'b0;
        end else begin
            rdy_sync_reg <= {rdy_sync_reg[SYNC_STAGES-2:0], ready_pin};
            if (rdy_sync_reg[1] == rdy_sync_reg[2]) begin
                rdy_lvl_reg <= rdy_sync_reg[2];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            int3_sync_reg <= '0;
            int3_lvl_reg  <= 1'b0;
            int3_prev_reg <= 1'b0;
        end else begin
            int3_sync_reg <= {int3_sync_reg[SYNC_STAGES-2:0], external_interrupt_three};
            if (int3_sync_reg[1] == int3_sync_reg[2]) begin
                int3_lvl_reg <= int3_sync_reg[2];
            end
            int3_prev_reg <= int3_lvl_reg;
        end
    end

    logic req_seen;
    logic int3_rise;
    assign req_seen  = !req_lvl_reg;
    assign int3_rise = int3_lvl_reg && !int3_prev_reg;

    // ************************************************
    // reset straps
    // ************************************************
    logic [1:0] strap_cnt_reg;
    logic       strap_done_reg;
    logic       strap_now;

    // the chain refills after release, so the strap is taken a few edges
    // late from the third stage, which the level register lags by an edge
    assign strap_now = !strap_done_reg && strap_cnt_reg == STRAP_WAIT;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            strap_cnt_reg  <= '0;
            strap_done_reg <= 1'b0;
        end else begin
            if (!strap_done_reg && strap_cnt_reg != STRAP_WAIT) begin
                strap_cnt_reg <= strap_cnt_reg + 2'h1;
            end
            if (strap_now) begin
                strap_done_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            big_endian <= 1'b0;
        end else if (strap_now) begin
            big_endian <= !rdy_sync_reg[2];
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            master_processor_halted <= 1'b1;
        end else if (strap_now) begin
            master_processor_halted <= req_sync_reg[2];
        end else if (master_processor_halted && strap_done_reg && int3_rise) begin
            master_processor_halted <= 1'b0;
        end
    end

    // ************************************************
    // bus ownership
    // ************************************************
    bus_state_t bus_state_reg;
    bus_state_t bus_state_next;

    // host request outranks refresh; grant waits only for the straps and for the pipe to drain
    always_comb begin
        bus_state_next = bus_state_reg;
        case (bus_state_reg)
            BUS_OWN: begin
                if (strap_done_reg && req_seen) begin
                    bus_state_next = BUS_DRAIN;
                end
            end
            BUS_DRAIN: begin
                if (!pipe_busy) begin
                    bus_state_next = BUS_GRANT;
                end
            end
            BUS_GRANT: begin
                if (!req_seen) begin
                    bus_state_next = BUS_OWN;
                end
            end
            default: begin
                bus_state_next = BUS_OWN;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bus_state_reg <= BUS_OWN;
        end else begin
            bus_state_reg <= bus_state_next;
        end
    end

    // reset puts float high at once; release waits for the straps
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bus_float <= FLOAT_RESET;
        end else begin
            bus_float <= !strap_done_reg || bus_state_next == BUS_GRANT
                         || (bus_float && bus_state_next == BUS_DRAIN);
        end
    end

    // grant is released on the registered synced level, so it lags
    // the pin by the synchroniser depth plus two register edges rather than being combinational
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            host_bus_grant_n <= GRANT_N_RESET;
        end else begin
            host_bus_grant_n <= bus_state_next != BUS_GRANT;
        end
    end

    // ************************************************
    // soft reset
    // ************************************************
    logic sw_pend_reg;
    logic sw_fire;

    assign sw_fire = sw_pend_reg && !pipe_busy;

    // a new command in the firing cycle stays pending
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sw_pend_reg <= 1'b0;
        end else begin
            sw_pend_reg <= sw_reset_cmd || (sw_pend_reg && pipe_busy);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            launch_enable <= 1'b0;
        end else begin
            launch_enable <= strap_done_reg && bus_state_next == BUS_OWN
                             && !req_seen && !sw_pend_reg && !sw_reset_cmd;
        end
    end

    // hardware reset holds these until release; soft reset pulses
    // them but leaves present bits and refresh control alone
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            requests_abort   <= 1'b1;
            ctrl_state_reset <= 1'b1;
            processor_reset  <= 1'b1;
        end else begin
            requests_abort   <= sw_fire;
            ctrl_state_reset <= sw_fire;
            processor_reset  <= sw_fire;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_present_clear  <= 1'b1;
            refresh_ctrl_reset <= 1'b1;
        end else begin
            cfg_present_clear  <= 1'b0;
            refresh_ctrl_reset <= 1'b0;
        end
    end

    // ************************************************
    // priority output
    // ************************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            priority_req <= PRIORITY_RESET;
        end else begin
            priority_req <= refresh_backlog >= BACKLOG_W'(URGENT_BACKLOG)
                            || external_packet_transfer_pend;
        end
    end

    // ************************************************
    // power-up sequence
    // ************************************************
    seq_state_t seq_state_reg;
    seq_state_t seq_state_next;
    logic [5:0] ref_cnt_reg;
    logic       sdram_seen_reg;
    logic       owned;

    // the sequence only issues its requests while we hold the bus
    assign owned = strap_done_reg && bus_state_reg == BUS_OWN && !req_seen;

    always_comb begin
        seq_state_next = seq_state_reg;
        case (seq_state_reg)
            SEQ_STRAP: begin
                if (strap_done_reg) begin
                    seq_state_next = SEQ_REFRESH;
                end
            end
            SEQ_REFRESH: begin
                if (ref_cnt_reg == INIT_REFRESH_COUNT) begin
                    seq_state_next = sdram_seen_reg ? SEQ_DEACTIVATE_ALL_BANKS : SEQ_FILL;
                end
            end
            SEQ_DEACTIVATE_ALL_BANKS: begin
                if (deactivate_all_banks_done) begin
                    seq_state_next = SEQ_FILL;
                end
            end
            SEQ_FILL: begin
                if (fill_done) begin
                    seq_state_next = SEQ_RUN;
                end
            end
            SEQ_RUN: begin
                seq_state_next = SEQ_RUN;
            end
            default: begin
                seq_state_next = SEQ_STRAP;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            seq_state_reg <= SEQ_STRAP;
        end else begin
            seq_state_reg <= seq_state_next;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ref_cnt_reg    <= '0;
            sdram_seen_reg <= 1'b0;
        end else if (seq_state_reg == SEQ_REFRESH) begin
            if (refresh_done && ref_cnt_reg != INIT_REFRESH_COUNT) begin
                ref_cnt_reg <= ref_cnt_reg + 6'h01;
            end
            if (sdram_present && refresh_done) begin
                sdram_seen_reg <= 1'b1;
            end
        end
    end

    // refreshes run even with the processor halted
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            init_refresh_req <= 1'b0;
            deactivate_all_banks_req         <= 1'b0;
        end else begin
            init_refresh_req <= owned && seq_state_next == SEQ_REFRESH;
            deactivate_all_banks_req         <= owned && seq_state_next == SEQ_DEACTIVATE_ALL_BANKS;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            first_fill_req  <= 1'b0;
            first_fill_addr <= '0;
        end else begin
            first_fill_req  <= owned && seq_state_next == SEQ_FILL
                               && !master_processor_halted;
            first_fill_addr <= FIRST_FILL_ADDR;
        end
    end

endmodule // host_bus_handoff_and_reset
